// >>> design/breaker_auto_reclose_sequencer.v
// Auto-reclose sequencer: request channels, shot sequencing, breaker commands, APB settings.
// Assumes synchronous inputs, one clock, synchronous reset and an APB master.
`timescale 1ns/1ps
`include "recloser_defs.vh"
module breaker_auto_reclose_sequencer #(
  parameter integer TICK_CYCLES = (`TICK_PERIOD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [15:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [1:0] i_setting_group,
  input wire [4:0] i_reclose_request_channel,
  input wire [4:0] i_request_from_pickup,
  input wire i_recloser_on_off_input,
  input wire i_lock_reset,
  input wire [4:0] i_obj_open,
  input wire [4:0] i_obj_closed,
  input wire [4:0] i_obj_close_cmd_any,
  output reg [4:0] o_open_cmd,
  output reg [4:0] o_close_cmd,
  output reg o_ready,
  output reg o_locked,
  output reg [3:0] o_state,
  output reg [2:0] o_channel,
  output reg [2:0] o_shot
);
  localparam integer CR_DEF = `CLOSE_RECLAIM_DEF_US / `TICK_PERIOD_US;
  localparam integer TBL_DEPTH = 1024;

  // Per setting group general settings.
  reg [`GEN_W-1:0] gen_cfg [0:`NUM_GRP-1];
  reg [24:0] shot_en_cfg [0:`NUM_GRP-1];
  reg [`TIME_W-1:0] lockout_cfg [0:`NUM_GRP-1];
  reg [`TIME_W-1:0] close_rcl_cfg [0:`NUM_GRP-1];
  // Shot time table indexed {group, channel, shot, kind}.
  reg [`TIME_W-1:0] shot_time [0:TBL_DEPTH-1];

  reg [3:0] state;
  reg [2:0] ch;
  reg [2:0] shot;
  reg [4:0] req_prev;
  reg [3:0] next_state;
  reg [2:0] next_ch;
  reg [2:0] next_shot;
  reg main_load;
  reg [`TIME_W-1:0] main_val;
  reg act_load;
  reg cr_load;
  reg [2:0] sel_ch;
  reg [2:0] fs;
  integer i, j;

  wire tick;
  wire main_exp;
  wire act_exp;
  wire cr_exp;

  // Live selection by the active setting group.
  wire [`GEN_W-1:0] gen = gen_cfg[i_setting_group];
  wire [2:0] obj_raw = gen[`GEN_OBJ_LSB+2:`GEN_OBJ_LSB];
  wire [2:0] obj = (obj_raw < `NUM_OBJ) ? obj_raw : 3'h0;
  wire [4:0] obj_hot = 5'h01 << obj;
  wire obj_is_open = i_obj_open[obj];
  wire obj_is_closed = i_obj_closed[obj];
  wire close_any = i_obj_close_cmd_any[obj];
  wire in_use = gen[`GEN_EN] & (~gen[`GEN_ONOFF] | i_recloser_on_off_input);
  wire [4:0] req_rise = i_reclose_request_channel & ~req_prev;
  wire req_new = |req_rise;
  wire [24:0] en_all = shot_en_cfg[i_setting_group];
  wire [9:0] tbase = {i_setting_group, ch, shot, 2'h0};
  wire [`TIME_W-1:0] t_start = shot_time[tbase | {8'h00, `K_START}];
  wire [`TIME_W-1:0] t_dead = shot_time[tbase | {8'h00, `K_DEAD}];
  wire [`TIME_W-1:0] t_act = shot_time[tbase | {8'h00, `K_ACT}];
  wire [`TIME_W-1:0] t_recl = shot_time[tbase | {8'h00, `K_RECL}];
  wire [`TIME_W-1:0] t_lockout = lockout_cfg[i_setting_group];
  wire cr_running = ~cr_exp;

  // First enabled shot of channel c at or after shot s, else NO_SHOT.
  function [2:0] find_shot;
    input [24:0] en;
    input [2:0] c;
    input [2:0] s;
    integer k;
    begin
      find_shot = `NO_SHOT;
      for (k = `NUM_SHOT - 1; k >= 0; k = k - 1) begin
        if (k >= s && en[c * `NUM_SHOT + k]) begin
          find_shot = k[2:0];
        end
      end
    end
  endfunction

  tick_divider #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(tick)
  );

  countdown_timer #(
    .W(`TIME_W)
  ) u_main_tmr (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_load(main_load),
    .i_value(main_val),
    .o_expired(main_exp)
  );

  countdown_timer #(
    .W(`TIME_W)
  ) u_act_tmr (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_load(act_load),
    .i_value(t_act),
    .o_expired(act_exp)
  );

  countdown_timer #(
    .W(`TIME_W)
  ) u_cr_tmr (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_load(cr_load),
    .i_value(close_rcl_cfg[i_setting_group]),
    .o_expired(cr_exp)
  );

  // Lowest-numbered channel with a fresh request wins.
  always @* begin
    sel_ch = 3'h0;
    for (i = `NUM_CH - 1; i >= 0; i = i - 1) begin
      if (req_rise[i]) begin
        sel_ch = i[2:0];
      end
    end
  end

  always @* begin
    next_state = state;
    next_ch = ch;
    next_shot = shot;
    main_load = 1'b0;
    main_val = t_recl;
    act_load = 1'b0;
    cr_load = close_any & ~o_close_cmd[obj];
    fs = `NO_SHOT;
    if (!in_use) begin
      next_state = `ST_READY;
    end else begin
      case (state)
        `ST_READY: begin
          if (req_new) begin
            fs = find_shot(en_all, sel_ch, 3'h0);
            if (cr_running) begin
              next_state = `ST_LOCKED;
            end else if (fs != `NO_SHOT) begin
              next_ch = sel_ch;
              next_shot = fs;
              next_state = `ST_ARM;
            end
          end
        end
        `ST_ARM: begin
          if (i_request_from_pickup[ch]) begin
            main_load = 1'b1;
            main_val = t_start;
            next_state = `ST_START;
          end else if (t_start != {`TIME_W{1'b0}}) begin
            next_state = `ST_READY;
          end else begin
            next_state = `ST_OPEN;
          end
        end
        `ST_START: begin
          if (!i_reclose_request_channel[ch]) begin
            next_state = `ST_READY;
          end else if (main_exp) begin
            next_state = `ST_OPEN;
          end
        end
        `ST_OPEN: begin
          if (obj_is_open) begin
            main_load = 1'b1;
            main_val = t_dead;
            next_state = `ST_DEAD;
          end
        end
        `ST_DEAD: begin
          if (main_exp) begin
            next_state = `ST_CLOSE;
          end
        end
        `ST_CLOSE: begin
          if (obj_is_closed) begin
            main_load = 1'b1;
            main_val = t_recl;
            act_load = 1'b1;
            next_state = `ST_ACTION;
          end
        end
        `ST_ACTION: begin
          // The breaker is never opened here, whatever the fault does.
          if (req_new) begin
            next_state = `ST_HOLD;
          end else if (act_exp) begin
            next_state = `ST_RECLAIM;
          end
        end
        `ST_RECLAIM: begin
          if (req_new) begin
            fs = find_shot(en_all, ch, shot + 3'h1);
            if (fs == `NO_SHOT) begin
              next_state = `ST_TRIP;
            end else begin
              next_shot = fs;
              next_state = `ST_ARM;
            end
          end else if (main_exp) begin
            cr_load = cr_load | gen[`GEN_GENRECL];
            if (t_lockout == {`TIME_W{1'b0}}) begin
              next_state = `ST_READY;
            end else begin
              main_load = 1'b1;
              main_val = t_lockout;
              next_state = `ST_LOCKOUT;
            end
          end
        end
        `ST_LOCKOUT: begin
          if (req_new) begin
            next_state = `ST_TRIP;
          end else if (main_exp) begin
            next_state = `ST_READY;
          end
        end
        `ST_TRIP: begin
          if (obj_is_open) begin
            next_state = `ST_LOCKED;
          end
        end
        `ST_HOLD: begin
          if (main_exp) begin
            next_state = `ST_READY;
          end
        end
        `ST_LOCKED: begin
          if (i_lock_reset || (gen[`GEN_CLRCLOSE] && close_any)) begin
            next_state = `ST_READY;
          end
        end
        default: begin
          next_state = `ST_READY;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= `ST_READY;
      ch <= 3'h0;
      shot <= 3'h0;
      req_prev <= 5'h00;
      o_open_cmd <= 5'h00;
      o_close_cmd <= 5'h00;
      o_ready <= 1'b0;
      o_locked <= 1'b0;
      o_state <= `ST_READY;
      o_channel <= 3'h0;
      o_shot <= 3'h0;
    end else begin
      state <= next_state;
      ch <= next_ch;
      shot <= next_shot;
      req_prev <= i_reclose_request_channel;
      o_open_cmd <= (next_state == `ST_OPEN || next_state == `ST_TRIP) ? obj_hot : 5'h00;
      o_close_cmd <= (next_state == `ST_CLOSE) ? obj_hot : 5'h00;
      o_ready <= in_use && next_state == `ST_READY;
      o_locked <= next_state == `ST_LOCKED || next_state == `ST_HOLD;
      o_state <= next_state;
      o_channel <= next_ch;
      o_shot <= next_shot;
    end
  end

  // APB slave: no wait states, ready registered in the setup cycle.
  wire grp_hit = i_paddr[15:12] == `A_GRP_HI && i_paddr[11:6] == 6'h00;
  wire [1:0] ag = i_paddr[5:4];
  wire [1:0] ar = i_paddr[3:2];
  wire st_hit = i_paddr[15:2] == `A_STATUS;
  wire [9:0] tidx = i_paddr[11:2];
  wire tbl_hit = i_paddr[15:12] == `A_TABLE_HI && tidx[7:5] < `NUM_CH && tidx[4:2] < `NUM_SHOT;
  wire hit = grp_hit | st_hit | tbl_hit;
  wire wr_go = i_psel & i_penable & o_pready & i_pwrite & hit;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      for (j = 0; j < `NUM_GRP; j = j + 1) begin
        gen_cfg[j] <= {`GEN_W{1'b0}};
        shot_en_cfg[j] <= 25'h0000000;
        lockout_cfg[j] <= {`TIME_W{1'b0}};
        close_rcl_cfg[j] <= CR_DEF[`TIME_W-1:0];
      end
      for (j = 0; j < TBL_DEPTH; j = j + 1) begin
        shot_time[j] <= {`TIME_W{1'b0}};
      end
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      o_prdata <= 32'h00000000;
      if (i_psel && !i_penable && !i_pwrite) begin
        if (grp_hit) begin
          case (ar)
            `A_R_GEN: o_prdata <= {25'h0000000, gen_cfg[ag]};
            `A_R_SHOTEN: o_prdata <= {7'h00, shot_en_cfg[ag]};
            `A_R_LOCKOUT: o_prdata <= {10'h000, lockout_cfg[ag]};
            default: o_prdata <= {10'h000, close_rcl_cfg[ag]};
          endcase
        end else if (st_hit) begin
          o_prdata <= {14'h0000, cr_running, o_ready, o_locked, i_setting_group,
            o_state, o_channel, o_shot, o_open_cmd[0], o_close_cmd[0], 1'b0};
        end else if (tbl_hit) begin
          o_prdata <= {10'h000, shot_time[tidx]};
        end
      end
      if (wr_go && grp_hit) begin
        case (ar)
          `A_R_GEN: gen_cfg[ag] <= i_pwdata[`GEN_W-1:0];
          `A_R_SHOTEN: shot_en_cfg[ag] <= i_pwdata[24:0];
          `A_R_LOCKOUT: lockout_cfg[ag] <= i_pwdata[`TIME_W-1:0];
          default: close_rcl_cfg[ag] <= i_pwdata[`TIME_W-1:0];
        endcase
      end
      if (wr_go && tbl_hit) begin
        shot_time[tidx] <= i_pwdata[`TIME_W-1:0];
      end
    end
  end
endmodule // breaker_auto_reclose_sequencer

// >>> design/recloser_defs.vh
// Constants for the breaker auto-reclose sequencer: timing, APB map, fields, states.
// Assumes a 25 MHz system clock and a 32-bit APB master.
//
// Overview of operation
// - Disabled shots are skipped; enabled shots run with their own timers.
// - Request must stay active for the shot starting delay before opening.
// - Starting delay only qualifies requests coming from a protection pickup.
// - Operate-sourced request with nonzero starting delay never starts a sequence.
// - Dead time starts at breaker open; at expiry the breaker is closed.
// - After reclose the breaker stays closed until the action time ends.
// - A new request during action time locks for the rest of reclaim.
// - Action time of zero removes the arcing or discrimination interval.
// - Shot reclaim starts at reclose; a request after action time goes to the next enabled shot, else trips and locks.
// - Lock-out timer follows success; zero returns straight to ready.
// - Request during post-success lock-out opens the breaker and locks.
// - Close reclaim starts on manual close or success with general reclaim.
// - Any request in ready state while close reclaim runs puts the sequencer in lock.
// - Lock clears by reset input, or by any close command if configured.
// - General reclaim option decides whether success starts close reclaim.
// - All enables, times and options are per setting group, live.
// - One breaker object of five is controlled, object one by default.
// - With on/off option set, the on/off input must be active.
`ifndef RECLOSER_DEFS_VH
`define RECLOSER_DEFS_VH

`define CLK_PERIOD_NS 40
`define TICK_PERIOD_US 500
`define CLOSE_RECLAIM_DEF_US 10000000
`define TIME_W 22
`define NUM_CH 5
`define NUM_SHOT 5
`define NUM_OBJ 5
`define NUM_GRP 4
`define NO_SHOT 3'h5

`define GEN_EN 0
`define GEN_ONOFF 1
`define GEN_CLRCLOSE 2
`define GEN_GENRECL 3
`define GEN_OBJ_LSB 4
`define GEN_W 7

`define K_START 2'h0
`define K_DEAD 2'h1
`define K_ACT 2'h2
`define K_RECL 2'h3

`define A_GRP_HI 4'h0
`define A_R_GEN 2'h0
`define A_R_SHOTEN 2'h1
`define A_R_LOCKOUT 2'h2
`define A_R_CLOSERCL 2'h3
`define A_STATUS 14'h0010
`define A_TABLE_HI 4'h1

`define ST_READY 4'h0
`define ST_ARM 4'h1
`define ST_START 4'h2
`define ST_OPEN 4'h3
`define ST_DEAD 4'h4
`define ST_CLOSE 4'h5
`define ST_ACTION 4'h6
`define ST_RECLAIM 4'h7
`define ST_LOCKOUT 4'h8
`define ST_TRIP 4'h9
`define ST_HOLD 4'hA
`define ST_LOCKED 4'hB

`endif

// >>> design/tick_divider.v
// One-cycle tick every DIV system clocks; the common time base of all timers.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module tick_divider #(
  parameter integer DIV = 12500
) (
  input wire i_clk,
  input wire i_sys_rst,
  output reg o_tick
);
  localparam integer LAST_I = DIV - 1;
  localparam [23:0] LAST = LAST_I[23:0];
  reg [23:0] cnt;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt <= 24'h0;
      o_tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= 24'h0;
      o_tick <= 1'b1;
    end else begin
      cnt <= cnt + 24'h1;
      o_tick <= 1'b0;
    end
  end
endmodule // tick_divider

// >>> design/countdown_timer.v
// Loadable down counter in ticks; o_expired is high when idle or finished.
// Assumes i_tick is a one-cycle enable from the common divider.
`timescale 1ns/1ps
module countdown_timer #(
  parameter integer W = 22
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_tick,
  input wire i_load,
  input wire [W-1:0] i_value,
  output reg o_expired
);
  reg [W-1:0] count;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      count <= {W{1'b0}};
      o_expired <= 1'b1;
    end else if (i_load) begin
      count <= i_value;
      o_expired <= 1'b0;
    end else if (!o_expired) begin
      if (count == {W{1'b0}}) begin
        o_expired <= 1'b1;
      end else if (i_tick) begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // countdown_timer

// >>> dv/breaker_model.sv
// Breaker object model: five objects whose positions follow the commands.
// Assumes one-hot commands held until the position changes; manual close acts at once.
`timescale 1ns/1ps
module breaker_model (
  input wire logic i_clk,
  input wire logic [4:0] i_open_cmd,
  input wire logic [4:0] i_close_cmd,
  input wire logic [4:0] i_man_close,
  input wire logic [3:0] i_delay,
  output logic [4:0] o_open,
  output logic [4:0] o_closed,
  output logic [4:0] o_close_any
);
  logic [3:0] cnt = 0;
  logic [4:0] pos = 5'h1F;
  assign o_closed = pos;
  assign o_open = ~pos;
  assign o_close_any = i_close_cmd | i_man_close;
  always @(posedge i_clk) begin
    if (((i_open_cmd & pos) | (i_close_cmd & ~pos)) == 5'h00) begin
      cnt <= 0;
      pos <= pos | i_man_close;
    end else if (cnt < i_delay) begin
      cnt <= cnt + 1;
      pos <= pos | i_man_close;
    end else begin
      cnt <= 0;
      pos <= (pos & ~i_open_cmd) | i_close_cmd | i_man_close;
    end
  end
endmodule // breaker_model

// >>> dv/breaker_auto_reclose_sequencer_asserts.sv
// Checker for the sequencer: bus answer timing, breaker commands, lock and reset.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
`include "recloser_defs.vh"
module reclose_asserts (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_lock_reset,
  input wire [4:0] i_obj_open,
  input wire [4:0] i_obj_close_cmd_any,
  input wire [4:0] o_open_cmd,
  input wire [4:0] o_close_cmd,
  input wire o_ready,
  input wire o_locked,
  input wire [3:0] o_state
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence answer_s;
    o_pready ##1 !o_pready;
  endsequence
  sequence open_seen_s;
    o_state == `ST_OPEN && (i_obj_open & o_open_cmd) != 5'h00;
  endsequence
  bus_answer_a: assert property (setup_s |=> answer_s)
    else $error("bus answer not one cycle after setup");
  err_timing_a: assert property (o_pslverr |-> o_pready)
    else $error("error flag without ready");
  reset_idle_a: assert property (disable iff (1'b0) i_sys_rst |=>
    (o_state == `ST_READY && o_open_cmd == 5'h00 && o_close_cmd == 5'h00))
    else $error("not idle after reset");
  one_object_a: assert property ((o_open_cmd | o_close_cmd) != 5'h00 |->
    $onehot(o_open_cmd | o_close_cmd)) else $error("command not one-hot");
  close_issue_a: assert property (o_state == `ST_CLOSE |->
    o_close_cmd != 5'h00 && o_open_cmd == 5'h00) else $error("no close in close state");
  dead_start_a: assert property (open_seen_s |-> ##[1:2] o_state == `ST_DEAD)
    else $error("dead time not started at open");
  action_kept_a: assert property (o_state == `ST_ACTION |-> o_open_cmd == 5'h00)
    else $error("breaker opened in action time");
  locked_flag_a: assert property (o_locked ==
    (o_state == `ST_LOCKED || o_state == `ST_HOLD)) else $error("locked flag wrong");
  lock_held_a: assert property (o_state == `ST_LOCKED && !i_lock_reset &&
    i_obj_close_cmd_any == 5'h00 |=> o_state == `ST_LOCKED) else $error("lock left");
  ready_state_a: assert property (o_ready |-> o_state == `ST_READY)
    else $error("ready outside ready state");
endmodule // reclose_asserts

// >>> dv/breaker_auto_reclose_sequencer_bench.sv
// Self-checking bench for the sequencer with a breaker model and an APB master.
// Assumes the design include path holds recloser_defs.vh; tick shortened to 4 clocks.
`timescale 1ns/1ps
`include "recloser_defs.vh"
module breaker_auto_reclose_sequencer_bench;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, onoff = 0, lrst = 0, e;
  logic [15:0] pa = 0;
  logic [31:0] pwd = 0, q, prdata;
  logic [4:0] req = 0, pick = 0, man = 0, bo, bc, bany, ocmd, ccmd;
  logic [1:0] grp = 0;
  logic [3:0] dly = 1, state;
  logic [2:0] chn, shot;
  logic pready, pslverr, ready, locked;
  int num_errors = 0, total_checks = 0;
  always #20 clk = ~clk;
  breaker_auto_reclose_sequencer #(.TICK_CYCLES(4)) breaker_auto_reclose_sequencer_i (
    .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_setting_group(grp), .i_reclose_request_channel(req),
    .i_request_from_pickup(pick), .i_recloser_on_off_input(onoff), .i_lock_reset(lrst),
    .i_obj_open(bo), .i_obj_closed(bc), .i_obj_close_cmd_any(bany), .o_open_cmd(ocmd),
    .o_close_cmd(ccmd), .o_ready(ready), .o_locked(locked), .o_state(state),
    .o_channel(chn), .o_shot(shot));
  breaker_model breaker_model_i (.i_clk(clk), .i_open_cmd(ocmd), .i_close_cmd(ccmd),
    .i_man_close(man), .i_delay(dly), .o_open(bo), .o_closed(bc), .o_close_any(bany));
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pen <= 0;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  function logic [15:0] ta(input int c, input int s, input int k);
    return 16'(4096 + 4 * (c * 32 + s * 4 + k));
  endfunction
  task tm(input int c, input int s, input int t0, input int t1, input int t2, input int t3);
    apb(1, ta(c, s, 0), t0);
    apb(1, ta(c, s, 1), t1);
    apb(1, ta(c, s, 2), t2);
    apb(1, ta(c, s, 3), t3);
  endtask
  task wst(input logic [3:0] s);
    int n;
    n = 0;
    while (state !== s && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(state, s, "state");
  endtask
  task t_regs;
    apb(0, 16'h0000, 0);
    chk(q, 0, "gen");
    apb(0, 16'h000C, 0);
    chk(q, 20000, "closercl");
    apb(0, ta(5, 0, 0), 0);
    chk(e, 1, "slverr");
    apb(1, 16'h0000, 32'h11);
    apb(1, 16'h0004, 32'h25);
    apb(0, 16'h0040, 0);
    chk(q[16:9], 8'h80, "status");
    tm(0, 0, 3, 2, 2, 10);
    tm(0, 2, 0, 1, 0, 3);
    tm(1, 0, 2, 1, 4, 12);
    $display("done regs");
  endtask
  task t_full;
    req[0] <= 1;
    pick[0] <= 1;
    repeat (6) @(posedge clk);
    chk(ocmd, 0, "early open");
    wst(`ST_OPEN);
    chk(ocmd, 5'h02, "open obj");
    req[0] <= 0;
    wst(`ST_RECLAIM);
    req[0] <= 1;
    wst(`ST_OPEN);
    chk(shot, 2, "shot");
    req[0] <= 0;
    wst(`ST_READY);
    apb(0, 16'h0040, 0);
    chk(q[17], 0, "gen reclaim");
    $display("done full");
  endtask
  task t_oper;
    req[1] <= 1;
    repeat (20) @(posedge clk);
    chk(state, `ST_READY, "refuse");
    req[1] <= 0;
    apb(1, ta(1, 0, 0), 0);
    req[1] <= 1;
    wst(`ST_OPEN);
    chk(chn, 1, "channel");
    req[1] <= 0;
    wst(`ST_CLOSE);
    chk(ccmd, 5'h02, "close obj");
    wst(`ST_ACTION);
    req[1] <= 1;
    repeat (2) @(posedge clk);
    chk(state, `ST_HOLD, "hold");
    req[1] <= 0;
    wst(`ST_READY);
    $display("done oper");
  endtask
  task t_lock;
    dly <= 6;
    apb(1, 16'h0008, 20);
    req[1] <= 1;
    wst(`ST_OPEN);
    req[1] <= 0;
    wst(`ST_LOCKOUT);
    req[1] <= 1;
    wst(`ST_LOCKED);
    chk(bo, 5'h02, "tripped");
    chk(locked, 1, "locked flag");
    req[1] <= 0;
    repeat (30) @(posedge clk);
    chk(state, `ST_LOCKED, "held");
    lrst <= 1;
    @(posedge clk);
    lrst <= 0;
    wst(`ST_READY);
    $display("done lock");
  endtask
  task t_close;
    dly <= 1;
    apb(1, 16'h000C, 8);
    man <= 5'h02;
    @(posedge clk);
    man <= 0;
    repeat (3) @(posedge clk);
    apb(0, 16'h0040, 0);
    chk(q[17], 1, "closercl run");
    req[1] <= 1;
    wst(`ST_LOCKED);
    req[1] <= 0;
    apb(1, 16'h0000, 32'h15);
    man <= 5'h02;
    @(posedge clk);
    man <= 0;
    wst(`ST_READY);
    repeat (50) @(posedge clk);
    apb(1, 16'h0000, 32'h1D);
    req[1] <= 1;
    wst(`ST_OPEN);
    req[1] <= 0;
    wst(`ST_LOCKOUT);
    apb(0, 16'h0040, 0);
    chk(q[17], 1, "gen reclaim on");
    wst(`ST_READY);
    $display("done close");
  endtask
  task t_group;
    grp <= 1;
    repeat (2) @(posedge clk);
    chk(ready, 0, "grp1");
    grp <= 0;
    repeat (2) @(posedge clk);
    chk(ready, 1, "grp0");
    apb(1, 16'h0000, 32'h13);
    repeat (2) @(posedge clk);
    chk(ready, 0, "off");
    onoff <= 1;
    repeat (2) @(posedge clk);
    chk(ready, 1, "on");
    $display("done group");
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_full();
    t_oper();
    t_lock();
    t_close();
    t_group();
    conclude();
  end
  initial begin
    #(40 * 30000);
    num_errors++;
    conclude();
  end
endmodule // breaker_auto_reclose_sequencer_bench
bind breaker_auto_reclose_sequencer reclose_asserts reclose_asserts_i (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_lock_reset(i_lock_reset), .i_obj_open(i_obj_open),
  .i_obj_close_cmd_any(i_obj_close_cmd_any), .o_open_cmd(o_open_cmd),
  .o_close_cmd(o_close_cmd), .o_ready(o_ready), .o_locked(o_locked), .o_state(o_state));
